//--- core/tcu_defines.vh
`ifndef TCU_DEFINES_VH
`define TCU_DEFINES_VH

// Register offsets
`define TCU_ADDR_INTCTL 8'h0B
`define TCU_ADDR_INTCTL_B 8'h8B
`define TCU_ADDR_FLAGS 8'h0C
`define TCU_ADDR_CNT_LO 8'h0E
`define TCU_ADDR_CNT_HI 8'h0F
`define TCU_ADDR_CNT_CTL 8'h10
`define TCU_ADDR_CAP_LO 8'h15
`define TCU_ADDR_CAP_HI 8'h16
`define TCU_ADDR_CH_CTL 8'h17
`define TCU_ADDR_ENABLES 8'h8C

// Flag / enable bit positions
`define TCU_BIT_OVF 0
`define TCU_BIT_T2M 1
`define TCU_BIT_CAP 2
`define TCU_BIT_SER 3
`define TCU_BIT_ADC 6
`define TCU_FLAG_MASK 8'h4F

// Counter control bit positions
`define TCU_BIT_RUN 0
`define TCU_BIT_OSC 3
`define TCU_CNT_CTL_MASK 8'h3F

// Core interrupt control bits
`define TCU_BIT_GIE 7
`define TCU_BIT_PEIE 6

// Channel mode codes
`define TCU_MODE_OFF 4'h0
`define TCU_MODE_FALL 4'h4
`define TCU_MODE_RISE 4'h5
`define TCU_MODE_RISE4 4'h6
`define TCU_MODE_RISE16 4'h7
`define TCU_MODE_SPECIAL 4'hB

// Reset values and counter maximum
`define TCU_RST_BYTE 8'h00
`define TCU_RST_WORD 16'h0000
`define TCU_CNT_MAX 16'hFFFF

// Prescale terminal counts
`define TCU_PRE_4 4'h3
`define TCU_PRE_16 4'hF

`endif

//--- core/tcu_top.v
`timescale 1ns/1ps
`include "tcu_defines.vh"

module tcu_top (
   input wire clk_i,
   input wire sys_rst_i,
   input wire warm_rst_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire capture_pin_i,
   input wire conversion_done_i,
   input wire serial_port_i,
   input wire second_timer_match_i,
   input wire converter_enabled_i,
   output reg conversion_start_o,
   output wire low_power_osc_enable_o,
   output wire irq_o
);

   // Codes 01xx form the capture family
   function is_capture;
      input [3:0] m;
      begin
         is_capture = (m[3:2] == 2'b01);
      end
   endfunction

   // Shared write decode, one compare per address
   function reg_wr;
      input w;
      input [7:0] a;
      input [7:0] target;
      begin
         reg_wr = w && (a == target);
      end
   endfunction

   // Terminal prescale count, 1/4 unless 1/16 chosen
   function [3:0] prescale_term;
      input [3:0] m;
      begin
         if (m == `TCU_MODE_RISE16) begin
            prescale_term = `TCU_PRE_16;
         end else begin
            prescale_term = `TCU_PRE_4;
         end
      end
   endfunction

   // Replace one byte lane of a 16-bit word
   function [15:0] put_byte;
      input [15:0] word;
      input hi;
      input [7:0] b;
      begin
         put_byte = word;
         if (hi) begin
            put_byte[15:8] = b;
         end else begin
            put_byte[7:0] = b;
         end
      end
   endfunction

   reg [7:0] intctl_q;
   reg [7:0] flags_q;
   reg [7:0] enables_q;
   reg [7:0] cnt_ctl_q;

   reg [15:0] main_counter_q;
   reg [15:0] main_counter_d;
   reg [15:0] capture_holding_pair_q;
   reg [3:0] channel_mode_q;
   reg [3:0] prescale_q;
   reg [3:0] prescale_d;

   reg [2:0] pin_sync_q;
   reg rise;
   reg fall;
   reg cap_event;
   reg special_hit;
   reg overflow;
   reg [3:0] pre_term;
   reg [7:0] rdata_d;

   wire [7:0] flag_evt;
   wire [7:0] flag_mask;
   wire counter_run;
   wire special_mode;
   wire wr_lo;
   wire wr_hi;
   wire wr_flags;
   wire wr_enables;
   wire wr_intctl;
   wire wr_cnt_ctl;
   wire wr_ch_ctl;
   wire wr_cap_lo;
   wire wr_cap_hi;
   wire cnt_written;
   genvar gi;

   assign counter_run = cnt_ctl_q[`TCU_BIT_RUN];
   assign special_mode = (channel_mode_q == `TCU_MODE_SPECIAL);
   assign wr_lo = reg_wr(wr_i, addr_i, `TCU_ADDR_CNT_LO);
   assign wr_hi = reg_wr(wr_i, addr_i, `TCU_ADDR_CNT_HI);
   assign wr_flags = reg_wr(wr_i, addr_i, `TCU_ADDR_FLAGS);
   assign wr_enables = reg_wr(wr_i, addr_i, `TCU_ADDR_ENABLES);
   assign wr_intctl = reg_wr(wr_i, addr_i, `TCU_ADDR_INTCTL) ||
                      reg_wr(wr_i, addr_i, `TCU_ADDR_INTCTL_B);
   assign wr_cnt_ctl = reg_wr(wr_i, addr_i, `TCU_ADDR_CNT_CTL);
   assign wr_ch_ctl = reg_wr(wr_i, addr_i, `TCU_ADDR_CH_CTL);
   assign wr_cap_lo = reg_wr(wr_i, addr_i, `TCU_ADDR_CAP_LO);
   assign wr_cap_hi = reg_wr(wr_i, addr_i, `TCU_ADDR_CAP_HI);
   assign cnt_written = wr_lo || wr_hi;
   assign flag_mask = `TCU_FLAG_MASK;

   // Stage 0 may go metastable; only stage 1 reads it
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_sync_q[0] <= 1'b0;
      end else begin
         pin_sync_q[0] <= capture_pin_i;
      end
   end

   // Stage 1 settles the pin, stage 2 keeps the last level
   generate
      for (gi = 1; gi < 3; gi = gi + 1) begin : g_sync
         always @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               pin_sync_q[gi] <= 1'b0;
            end else begin
               pin_sync_q[gi] <= pin_sync_q[gi - 1];
            end
         end
      end
   endgenerate

   always @* begin
      rise = pin_sync_q[1] && !pin_sync_q[2];
      fall = !pin_sync_q[1] && pin_sync_q[2];
      pre_term = prescale_term(channel_mode_q);
      cap_event = 1'b0;
      prescale_d = prescale_q;
      if (!is_capture(channel_mode_q)) begin
         prescale_d = 4'h0;
      end else begin
         case (channel_mode_q)
            `TCU_MODE_FALL: cap_event = fall;
            `TCU_MODE_RISE: cap_event = rise;
            default: begin
               // Count kept across prescale change, capture may be early
               if (rise) begin
                  if (prescale_q >= pre_term) begin
                     cap_event = 1'b1;
                     prescale_d = 4'h0;
                  end else begin
                     prescale_d = prescale_q + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   always @* begin
      special_hit = special_mode && counter_run &&
                    (main_counter_q == capture_holding_pair_q);
      // A counter write this cycle suppresses the overflow flag
      overflow = counter_run && (main_counter_q == `TCU_CNT_MAX) &&
                 !special_hit && !cnt_written;
      main_counter_d = main_counter_q;
      if (special_hit) begin
         main_counter_d = `TCU_RST_WORD;
      end else if (counter_run) begin
         main_counter_d = main_counter_q + 16'h0001;
      end
      // Register write wins over trigger reset and counting
      if (wr_lo) begin
         main_counter_d = put_byte(main_counter_d, 1'b0, wdata_i);
      end
      if (wr_hi) begin
         main_counter_d = put_byte(main_counter_d, 1'b1, wdata_i);
      end
   end

   // Unused flag bits have no source and read zero
   assign flag_evt[`TCU_BIT_OVF] = overflow;
   assign flag_evt[`TCU_BIT_T2M] = second_timer_match_i;
   assign flag_evt[`TCU_BIT_CAP] = cap_event;
   assign flag_evt[`TCU_BIT_SER] = serial_port_i;
   assign flag_evt[`TCU_BIT_ADC] = conversion_done_i;
   assign flag_evt[5:4] = 2'b00;
   assign flag_evt[7] = 1'b0;

   // Hardware set beats a same-cycle software clear
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
         always @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               flags_q[gi] <= 1'b0;
            end else if (warm_rst_i) begin
               flags_q[gi] <= 1'b0;
            end else if (flag_evt[gi]) begin
               flags_q[gi] <= 1'b1;
            end else if (wr_flags) begin
               flags_q[gi] <= wdata_i[gi] & flag_mask[gi];
            end
         end
      end
   endgenerate

   // Enables share the flag layout, unused bits stay zero
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_enable
         always @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               enables_q[gi] <= 1'b0;
            end else if (warm_rst_i) begin
               enables_q[gi] <= 1'b0;
            end else if (wr_enables) begin
               enables_q[gi] <= wdata_i[gi] & flag_mask[gi];
            end
         end
      end
   endgenerate

   // Bit 0 keeps its value over a warm reset
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         intctl_q <= `TCU_RST_BYTE;
      end else if (warm_rst_i) begin
         intctl_q <= {7'h00, intctl_q[0]};
      end else if (wr_intctl) begin
         intctl_q <= wdata_i;
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         conversion_start_o <= 1'b0;
      end else if (warm_rst_i) begin
         conversion_start_o <= 1'b0;
      end else begin
         conversion_start_o <= special_hit && converter_enabled_i;
      end
   end

   // Counter survives a warm reset; only power-on clears it
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         main_counter_q <= `TCU_RST_WORD;
      end else begin
         main_counter_q <= main_counter_d;
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prescale_q <= 4'h0;
      end else if (warm_rst_i) begin
         prescale_q <= 4'h0;
      end else begin
         prescale_q <= prescale_d;
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         channel_mode_q <= `TCU_MODE_OFF;
      end else if (warm_rst_i) begin
         channel_mode_q <= `TCU_MODE_OFF;
      end else if (wr_ch_ctl) begin
         channel_mode_q <= wdata_i[3:0];
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_ctl_q <= `TCU_RST_BYTE;
      end else if (wr_cnt_ctl) begin
         cnt_ctl_q <= wdata_i & `TCU_CNT_CTL_MASK;
      end
   end

   // A capture overwrites any software write in its cycle
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         capture_holding_pair_q <= `TCU_RST_WORD;
      end else if (cap_event) begin
         capture_holding_pair_q <= main_counter_q;
      end else if (wr_cap_lo) begin
         capture_holding_pair_q <= put_byte(capture_holding_pair_q, 1'b0,
                                            wdata_i);
      end else if (wr_cap_hi) begin
         capture_holding_pair_q <= put_byte(capture_holding_pair_q, 1'b1,
                                            wdata_i);
      end
   end

   // Zero outside the read slot, so several slaves can be ORed
   always @* begin
      rdata_d = `TCU_RST_BYTE;
      if (rd_i) begin
         case (addr_i)
            `TCU_ADDR_INTCTL: rdata_d = intctl_q;
            `TCU_ADDR_INTCTL_B: rdata_d = intctl_q;
            `TCU_ADDR_FLAGS: rdata_d = flags_q;
            `TCU_ADDR_ENABLES: rdata_d = enables_q;
            `TCU_ADDR_CNT_LO: rdata_d = main_counter_q[7:0];
            `TCU_ADDR_CNT_HI: rdata_d = main_counter_q[15:8];
            `TCU_ADDR_CNT_CTL: rdata_d = cnt_ctl_q;
            `TCU_ADDR_CAP_LO: rdata_d = capture_holding_pair_q[7:0];
            `TCU_ADDR_CAP_HI: rdata_d = capture_holding_pair_q[15:8];
            `TCU_ADDR_CH_CTL: rdata_d = {4'h0, channel_mode_q};
            default: rdata_d = `TCU_RST_BYTE;
         endcase
      end
   end

   // No byte latch: a 16-bit read may tear while counting
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_o <= `TCU_RST_BYTE;
      end else begin
         rdata_o <= rdata_d;
      end
   end

   // Oscillator runs on its own; only the enable leaves here
   assign low_power_osc_enable_o = cnt_ctl_q[`TCU_BIT_OSC];
   assign irq_o = intctl_q[`TCU_BIT_GIE] && intctl_q[`TCU_BIT_PEIE] &&
                  |(flags_q & enables_q);

endmodule // tcu_top

//--- verif/tcu_chk.sv
`timescale 1ns/1ps
module tcu_chk (
   input wire clk_i,
   input wire sys_rst_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire conversion_done_i,
   input wire converter_enabled_i,
   input wire conversion_start_o,
   input wire low_power_osc_enable_o,
   input wire irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside its slot");
   unmapped_rd_a: assert property (
      rd_i && addr_i == 8'h01 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   flag_unused_a: assert property (
      rd_i && addr_i == 8'h0C |=> rdata_o[7] == 0 && rdata_o[5:4] == 0)
      else $error("unused flag bits set");
   adc_flag_a: assert property (
      rd_i && addr_i == 8'h0C && $past(conversion_done_i, 2) |=> rdata_o[6])
      else $error("conversion flag missed");
   osc_follow_a: assert property (
      wr_i && addr_i == 8'h10 |=> low_power_osc_enable_o == $past(wdata_i[3]))
      else $error("oscillator enable wrong");
   start_gate_a: assert property (
      conversion_start_o |-> $past(converter_enabled_i))
      else $error("start without converter");
   enable_rw_a: assert property (
      wr_i && addr_i == 8'h8C ##2 rd_i && addr_i == 8'h8C
      |=> rdata_o[2:0] == $past(wdata_i[2:0], 3))
      else $error("enable readback wrong");
   irq_gie_a: assert property (
      wr_i && addr_i == 8'h0B && !wdata_i[7] |=> !irq_o)
      else $error("irq with global enable off");
   cover property (conversion_start_o);
   cover property (irq_o);
   cover property (rd_i && addr_i == 8'h16);
endmodule // tcu_chk
bind tcu_top tcu_chk tcu_chk_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .conversion_done_i(conversion_done_i),
   .converter_enabled_i(converter_enabled_i),
   .conversion_start_o(conversion_start_o),
   .low_power_osc_enable_o(low_power_osc_enable_o), .irq_o(irq_o));

//--- verif/tcu_pin_model.sv
`timescale 1ns/1ps
module tcu_pin_model (output logic pin_o);
   initial pin_o = 1'b0;
   // Rising edges off the core clock grid to exercise the synchroniser; each falling edge comes 13 ns after its rise, so a 20 ns pulse keeps the clock phase
   task pulse(input int n);
      repeat (n) begin
         #7 pin_o = 1'b1;
         #13 pin_o = 1'b0;
      end
   endtask
endmodule // tcu_pin_model

//--- verif/testbench.sv
`timescale 1ns/1ps
`include "tcu_defines.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
   miscompares++; $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
   reg clk_i = 0, sys_rst_i = 1, warm = 0, wr_i = 0, rd_i = 0;
   reg [7:0] addr_i = 0, wdata_i = 0, d;
   reg cdone = 0, ser = 0, t2m = 0, cen = 1;
   reg [3:0] m;
   reg [15:0] v;
   wire [7:0] rdata_o;
   wire pin, cs, irq, osc;
   int miscompares = 0, checks = 0, i, k;
   tcu_pin_model tcu_pin_model_inst (.pin_o(pin));
   tcu_top tcu_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .warm_rst_i(warm), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .capture_pin_i(pin),
      .conversion_done_i(cdone), .serial_port_i(ser),
      .second_timer_match_i(t2m), .converter_enabled_i(cen),
      .conversion_start_o(cs), .low_power_osc_enable_o(osc), .irq_o(irq));
   initial forever #2.5 clk_i = ~clk_i;
   function int edges(input [3:0] md);
      return md == `TCU_MODE_RISE4 ? 4 : md == `TCU_MODE_RISE16 ? 16 : 1;
   endfunction
   task wr(input [7:0] a, input [7:0] x);
      @(posedge clk_i);
      addr_i <= a; wdata_i <= x; wr_i <= 1;
      @(posedge clk_i);
      wr_i <= 0;
   endtask
   task rd(input [7:0] a, output [7:0] x);
      @(posedge clk_i);
      addr_i <= a; rd_i <= 1;
      @(posedge clk_i);
      rd_i <= 0;
      @(negedge clk_i);
      x = rdata_o;
   endtask
   task conclude;
      if (miscompares == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #200000 miscompares++;
      conclude;
   end
   initial begin
      v = $urandom(32'hc778);
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 0;
      rd(8'h0C, d); `CHK("rst_flags", 8'h00, d)
      rd(8'h8C, d); `CHK("rst_en", 8'h00, d)
      rd(8'h01, d); `CHK("unmapped", 8'h00, d)
      v = $urandom;
      wr(8'h0C, v[7:0]); rd(8'h0C, d);
      `CHK("flags_rw", v[7:0] & `TCU_FLAG_MASK, d)
      wr(8'h0C, 8'h00);
      @(posedge clk_i) begin cdone <= 1; ser <= 1; t2m <= 1; end
      @(posedge clk_i) begin cdone <= 0; ser <= 0; t2m <= 0; end
      rd(8'h0C, d); `CHK("hw_flags", 8'h4A, d)
      wr(8'h0C, 8'h00); wr(8'h0F, 8'hFF); wr(8'h0E, 8'hFD);
      wr(8'h10, 8'h09);
      @(negedge clk_i) `CHK("osc_en", 1'b1, osc)
      repeat (8) @(posedge clk_i);
      wr(8'h10, 8'h00);
      rd(8'h0C, d); `CHK("ovf", 8'h01, d & 8'h01)
      wr(8'h8C, 8'h01); rd(8'h8C, d);
      `CHK("en_rw", 8'h01, d)
      wr(8'h0B, 8'hC0);
      @(negedge clk_i) `CHK("irq_on", 1'b1, irq)
      wr(8'h0C, 8'h00);
      @(negedge clk_i) `CHK("irq_off", 1'b0, irq)
      wr(8'h0B, 8'h00);
      for (i = 0; i < 4; i++) begin
         m = `TCU_MODE_FALL + i; v = $urandom;
         wr(8'h17, 8'h00); wr(8'h0C, 8'h00);
         wr(8'h0E, v[7:0]); wr(8'h0F, v[15:8]); wr(8'h17, {4'h0, m});
         tcu_pin_model_inst.pulse(edges(m) - 1);
         repeat (6) @(posedge clk_i);
         rd(8'h0C, d); `CHK("early", 8'h00, d & 8'h04)
         tcu_pin_model_inst.pulse(1);
         repeat (6) @(posedge clk_i);
         rd(8'h0C, d); `CHK("capflag", 8'h04, d & 8'h04)
         rd(8'h15, d); `CHK("caplo", v[7:0], d)
         rd(8'h16, d); `CHK("caphi", v[15:8], d)
      end
      wr(8'h0C, 8'h00); wr(8'h15, 8'h10); wr(8'h16, 8'h00);
      wr(8'h0E, 8'h00); wr(8'h0F, 8'h00); wr(8'h17, 8'h0B);
      wr(8'h10, 8'h01);
      k = 0;
      do @(negedge clk_i); while (cs !== 1'b1 && ++k < 200);
      k = 0;
      do begin @(negedge clk_i); k++; end while (cs !== 1'b1 && k < 200);
      `CHK("period", 17, k)
      @(posedge clk_i) cen <= 0;
      k = 0;
      repeat (40) begin @(negedge clk_i); if (cs) k++; end
      `CHK("gated", 0, k)
      @(posedge clk_i) cen <= 1;
      wr(8'h10, 8'h00); rd(8'h0C, d);
      `CHK("no_ovf", 8'h00, d & 8'h01)
      wr(8'h0E, 8'h5A); wr(8'h8C, 8'h04);
      @(posedge clk_i) warm <= 1;
      @(posedge clk_i) warm <= 0;
      rd(8'h0E, d); `CHK("warm_cnt", 8'h5A, d)
      rd(8'h8C, d); `CHK("warm_en", 8'h00, d)
      conclude;
   end
endmodule // testbench
